// File: rtl/tmr_map.svh
// register map, field positions, reset values and prescaler codes of the 16-bit timer
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

// ==========================================================================
// register indices; the APB byte address is four times the index
`define TMR_IDX_COUNT 16'h0100
`define TMR_IDX_PERIOD 16'h0102
`define TMR_IDX_CTRL 16'h0104
`define TMR_IDX_IRQ 16'h0106
`define TMR_IDX_OSC 16'h0108

// ==========================================================================
// reset values and writable-bit masks
`define TMR_RST_COUNT 16'h0000
`define TMR_RST_PERIOD 16'hFFFF
`define TMR_RST_CTRL 16'h0000
`define TMR_RST_IRQ 16'h0000
`define TMR_RST_OSC 16'h0000
`define TMR_CTRL_MASK 16'hA076
`define TMR_IRQ_MASK 16'h0003
`define TMR_OSC_MASK 16'h0002

// ==========================================================================
// timer_control fields
`define TMR_BIT_ON 15
`define TMR_BIT_STOP_IDLE 13
`define TMR_BIT_GATE 6
`define TMR_BIT_PS_HI 5
`define TMR_BIT_PS_LO 4
`define TMR_BIT_SYNC 2
`define TMR_BIT_SRC 1

// ==========================================================================
// irq register and oscillator_control fields
`define TMR_BIT_IRQ_FLAG 0
`define TMR_BIT_IRQ_EN 1
`define TMR_BIT_LPOSC 1

// ==========================================================================
// prescaler terminal counts (ratio minus one) and prescale codes
`define TMR_PS_CODE_1 2'h0
`define TMR_PS_CODE_8 2'h1
`define TMR_PS_CODE_64 2'h2
`define TMR_PS_CODE_256 2'h3
`define TMR_PS_TC_8 8'h07
`define TMR_PS_TC_64 8'h3F
`define TMR_PS_TC_256 8'hFF

`endif

// File: rtl/tmr_pkg.sv
// types shared by the 16-bit timer design files
package tmr_pkg;

  // ==========================================================================
  // ways of running, decoded from timer_control and oscillator_control
  typedef enum logic [2:0] {
    TMR_MODE_OFF,
    TMR_MODE_TIMER,
    TMR_MODE_GATED,
    TMR_MODE_SYNC_CNT,
    TMR_MODE_ASYNC_CNT,
    TMR_MODE_RTC
  } tmr_mode_e;

  // ==========================================================================
  // decoded timer_control fields
  typedef struct packed {
    logic timer_on;
    logic stop_in_idle;
    logic gate_accumulate_enable;
    logic [1:0] prescale_select;
    logic ext_clock_synchronize;
    logic clock_source_select;
  } tmr_ctrl_s;

  // ==========================================================================
  // one APB request as seen on the bus in the current cycle, setup or access
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } tmr_apb_req_s;

endpackage : tmr_pkg

// File: rtl/tmr_prescaler.sv
// input prescaler of the 16-bit timer: 1:1, 1:8, 1:64 or 1:256
`timescale 1ns/1ns
`include "tmr_map.svh"

module tmr_prescaler
  import tmr_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick_in,
  input wire logic [1:0] ps_sel,
  input wire logic clear,
  output logic tick_out
);

  logic [CNT_W-1:0] ps_cnt_r;
  logic [CNT_W-1:0] term;

  // terminal count of the selected ratio
  function automatic logic [CNT_W-1:0] term_of(input logic [1:0] sel);
    case (sel)
      `TMR_PS_CODE_8: term_of = CNT_W'(`TMR_PS_TC_8);
      `TMR_PS_CODE_64: term_of = CNT_W'(`TMR_PS_TC_64);
      `TMR_PS_CODE_256: term_of = CNT_W'(`TMR_PS_TC_256);
      default: term_of = '0;
    endcase
  endfunction : term_of

  assign term = term_of(ps_sel);
  assign tick_out = tick_in && (ps_cnt_r == term);

  // counter only moves on an input tick, so it is frozen while the timer is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_cnt_r <= '0;
    end else if (clear) begin
      ps_cnt_r <= '0;
    end else if (tick_in) begin
      ps_cnt_r <= (ps_cnt_r == term) ? '0 : ps_cnt_r + 1'b1;
    end
  end

endmodule : tmr_prescaler

// File: rtl/tmr_timer.sv
// 16-bit timer/counter with prescaler, gating, real-time clock mode and APB registers
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
`include "tmr_map.svh"

module tmr_timer
  import tmr_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clock_gate_pin,
  input wire logic lowpower_osc_clk,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  output logic timer_irq,
  output logic wake_event
);

  // ==========================================================================
  // register state
  logic [CNT_W-1:0] count_value_r;
  logic [CNT_W-1:0] period_value_r;
  logic [15:0] timer_control_r;
  logic timer_irq_flag_r;
  logic timer_irq_enable_r;
  logic lowpower_osc_enable_r;
  tmr_ctrl_s ctrl;

  // ==========================================================================
  // APB slave state
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  tmr_apb_req_s req;
  logic access;
  logic wr_access;
  logic wr_count;
  logic wr_period;
  logic wr_ctrl;
  logic wr_irq;
  logic wr_osc;

  // ==========================================================================
  // pin synchronisers and edges
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;
  logic lp_s1_r;
  logic lp_s2_r;
  logic lp_s3_r;
  logic ext_rise;
  logic ext_fall;
  logic lp_rise;

  // ==========================================================================
  // counting datapath
  tmr_mode_e mode;
  logic mode_tick;
  logic run_allowed;
  logic raw_tick;
  logic ps_tick;
  logic ps_clear;
  logic at_period;
  logic match_evt;
  logic gate_fall_evt;
  logic irq_r;
  logic wake_r;

  // ==========================================================================
  // decode helpers

  // true when the address selects the register of the given index
  function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
    logic [17:0] byte_addr;
    byte_addr = {idx, 2'b00};
    hits = (addr == byte_addr[ADDR_W-1:0]);
  endfunction : hits

  // read value of a register; unimplemented bits come back as zero
  function automatic logic [31:0] read_of(input logic [ADDR_W-1:0] addr);
    logic [15:0] v;
    v = 16'h0000;
    if (hits(addr, `TMR_IDX_COUNT)) begin
      v = count_value_r;
    end else if (hits(addr, `TMR_IDX_PERIOD)) begin
      v = period_value_r;
    end else if (hits(addr, `TMR_IDX_CTRL)) begin
      v = timer_control_r & `TMR_CTRL_MASK;
    end else if (hits(addr, `TMR_IDX_IRQ)) begin
      v[`TMR_BIT_IRQ_FLAG] = timer_irq_flag_r;
      v[`TMR_BIT_IRQ_EN] = timer_irq_enable_r;
    end else if (hits(addr, `TMR_IDX_OSC)) begin
      v[`TMR_BIT_LPOSC] = lowpower_osc_enable_r;
    end
    read_of = {16'h0000, v};
  endfunction : read_of

  // true for any of the five mapped registers
  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    mapped = hits(addr, `TMR_IDX_COUNT) || hits(addr, `TMR_IDX_PERIOD) ||
             hits(addr, `TMR_IDX_CTRL) || hits(addr, `TMR_IDX_IRQ) ||
             hits(addr, `TMR_IDX_OSC);
  endfunction : mapped

  // ==========================================================================
  // APB request bundle and strobes
  assign req.sel = psel;
  assign req.enable = penable;
  assign req.write = pwrite;
  assign req.addr = 12'(paddr);
  assign req.wdata = pwdata;

  // a transfer completes on the access-phase edge where pready is high
  assign access = req.sel && req.enable && pready_r;
  assign wr_access = access && req.write;
  assign wr_count = wr_access && hits(paddr, `TMR_IDX_COUNT);
  assign wr_period = wr_access && hits(paddr, `TMR_IDX_PERIOD);
  assign wr_ctrl = wr_access && hits(paddr, `TMR_IDX_CTRL);
  assign wr_irq = wr_access && hits(paddr, `TMR_IDX_IRQ);
  assign wr_osc = wr_access && hits(paddr, `TMR_IDX_OSC);

  // ==========================================================================
  // APB answer: no wait state, data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= req.sel && !req.enable;
      if (req.sel && !req.enable) begin
        pslverr_r <= !mapped(paddr);
        prdata_r <= req.write ? 32'h0000_0000 : read_of(paddr);
      end else if (access) begin
        pslverr_r <= 1'b0;
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

  // ==========================================================================
  // control registers; only implemented bits are stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_r <= `TMR_RST_CTRL;
    end else if (wr_ctrl) begin
      timer_control_r <= pwdata[15:0] & `TMR_CTRL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_value_r <= CNT_W'(`TMR_RST_PERIOD);
    end else if (wr_period) begin
      period_value_r <= pwdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq_enable_r <= 1'(`TMR_RST_IRQ >> `TMR_BIT_IRQ_EN);
    end else if (wr_irq) begin
      timer_irq_enable_r <= pwdata[`TMR_BIT_IRQ_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lowpower_osc_enable_r <= 1'b0;
    end else if (wr_osc) begin
      lowpower_osc_enable_r <= pwdata[`TMR_BIT_LPOSC];
    end
  end

  // field view of timer_control
  assign ctrl.timer_on = timer_control_r[`TMR_BIT_ON];
  assign ctrl.stop_in_idle = timer_control_r[`TMR_BIT_STOP_IDLE];
  assign ctrl.gate_accumulate_enable = timer_control_r[`TMR_BIT_GATE];
  assign ctrl.prescale_select = timer_control_r[`TMR_BIT_PS_HI:`TMR_BIT_PS_LO];
  assign ctrl.ext_clock_synchronize = timer_control_r[`TMR_BIT_SYNC];
  assign ctrl.clock_source_select = timer_control_r[`TMR_BIT_SRC];

  // ==========================================================================
  // pin synchronisers; edges look only at the second and third stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_clock_gate_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_s1_r <= 1'b0;
      lp_s2_r <= 1'b0;
      lp_s3_r <= 1'b0;
    end else begin
      lp_s1_r <= lowpower_osc_clk;
      lp_s2_r <= lp_s1_r;
      lp_s3_r <= lp_s2_r;
    end
  end

  assign ext_rise = ext_s2_r && !ext_s3_r;
  assign ext_fall = !ext_s2_r && ext_s3_r;
  assign lp_rise = lp_s2_r && !lp_s3_r;

  // ==========================================================================
  // mode decode; the low-power oscillator leaves only the rtc mode usable
  always_comb begin
    if (!ctrl.timer_on) begin
      mode = TMR_MODE_OFF;
    end else if (lowpower_osc_enable_r) begin
      // normal timer and counter modes are disabled here
      mode = (ctrl.clock_source_select && !ctrl.gate_accumulate_enable) ?
             TMR_MODE_RTC : TMR_MODE_OFF;
    end else if (!ctrl.clock_source_select) begin
      mode = ctrl.gate_accumulate_enable ? TMR_MODE_GATED : TMR_MODE_TIMER;
    end else begin
      mode = ctrl.ext_clock_synchronize ? TMR_MODE_SYNC_CNT : TMR_MODE_ASYNC_CNT;
    end
  end

  // ==========================================================================
  // input tick of each mode, before the prescaler
  always_comb begin
    case (mode)
      TMR_MODE_TIMER: mode_tick = 1'b1;
      TMR_MODE_GATED: mode_tick = ext_s2_r;
      TMR_MODE_SYNC_CNT: mode_tick = ext_rise;
      // one clock only: async edges still pass the pin synchroniser
      TMR_MODE_ASYNC_CNT: mode_tick = ext_rise;
      TMR_MODE_RTC: mode_tick = lp_rise;
      default: mode_tick = 1'b0;
    endcase
  end

  // idle stops every mode when stop_in_idle is set; sleep leaves only
  // asynchronous external counting, and the rtc only while ext_clock_synchronize is clear
  assign run_allowed = !(cpu_idle && ctrl.stop_in_idle) &&
                       (!cpu_sleep || (ctrl.clock_source_select &&
                                       !ctrl.ext_clock_synchronize));
  assign raw_tick = mode_tick && run_allowed;

  // ==========================================================================
  // prescaler; a clear only counts while the timer is on
  assign ps_clear = ctrl.timer_on && (wr_count ||
                    (wr_ctrl && !pwdata[`TMR_BIT_ON]));

  tmr_prescaler #(
    .CNT_W(8)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(raw_tick),
    .ps_sel(ctrl.prescale_select),
    .clear(ps_clear),
    .tick_out(ps_tick)
  );

  // ==========================================================================
  // count register
  assign at_period = (count_value_r == period_value_r);
  assign match_evt = ps_tick && at_period && !wr_count;
  assign gate_fall_evt = (mode == TMR_MODE_GATED) && ext_fall;

  // a software write beats a tick in the same cycle; control writes never touch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_r <= CNT_W'(`TMR_RST_COUNT);
    end else if (wr_count) begin
      count_value_r <= pwdata[CNT_W-1:0];
    end else if (ps_tick) begin
      count_value_r <= at_period ? CNT_W'(`TMR_RST_COUNT) : count_value_r + 1'b1;
    end
  end

  // ==========================================================================
  // interrupt flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq_flag_r <= 1'b0;
    end else if (match_evt || gate_fall_evt) begin
      timer_irq_flag_r <= 1'b1;
    end else if (wr_irq && !pwdata[`TMR_BIT_IRQ_FLAG]) begin
      timer_irq_flag_r <= 1'b0;
    end
  end

  // request level follows the flag one cycle later, gated by the enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= timer_irq_flag_r && timer_irq_enable_r;
    end
  end

  // carry-out wake-up pulse, only with the low-power oscillator in use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= match_evt && (mode == TMR_MODE_RTC);
    end
  end

  assign timer_irq = irq_r;
  assign wake_event = wake_r;

endmodule : tmr_timer

// File: testbench/tmr_timer_asserts.sv
// concurrent checks on the timer's apb and event outputs
`timescale 1ns/1ns
`include "tmr_map.svh"

module tmr_asserts
  import tmr_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ext_clock_gate_pin,
  input wire logic lowpower_osc_clk,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  input wire logic timer_irq,
  input wire logic wake_event
);
  localparam int A_CNT = `TMR_IDX_COUNT * 4;
  localparam int A_PRD = `TMR_IDX_PERIOD * 4;
  localparam int A_CTL = `TMR_IDX_CTRL * 4;
  localparam int A_IRQ = `TMR_IDX_IRQ * 4;
  localparam int A_OSC = `TMR_IDX_OSC * 4;
  logic wr_acc, wr_irq, map_hit, osc_r;
  logic [15:0] prd_r, ctl_r;

  // ==========================================================================
  // shadows of writable registers; read data is judged against them
  assign wr_acc = psel && penable && pready && pwrite;
  assign wr_irq = wr_acc && paddr == ADDR_W'(A_IRQ);
  assign map_hit = paddr inside {ADDR_W'(A_CNT), ADDR_W'(A_PRD), ADDR_W'(A_CTL), ADDR_W'(A_IRQ), ADDR_W'(A_OSC)};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prd_r <= `TMR_RST_PERIOD;
      ctl_r <= `TMR_RST_CTRL;
      osc_r <= 1'b0;
    end else if (wr_acc && paddr == ADDR_W'(A_PRD)) begin
      prd_r <= pwdata[15:0];
    end else if (wr_acc && paddr == ADDR_W'(A_CTL)) begin
      ctl_r <= pwdata[15:0] & `TMR_CTRL_MASK;
    end else if (wr_acc && paddr == ADDR_W'(A_OSC)) begin
      osc_r <= pwdata[`TMR_BIT_LPOSC];
    end
  end

  // ==========================================================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_period_readback: assert property (pready && !pwrite && paddr == ADDR_W'(A_PRD) |-> prdata == {16'h0000, prd_r})
    else $error("period read differs from last write");
  a_ctrl_readback: assert property (pready && !pwrite && paddr == ADDR_W'(A_CTL) |-> prdata == {16'h0000, ctl_r})
    else $error("control read shows unimplemented bits");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_unmapped_err: assert property (pready && !map_hit |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (pready && map_hit |-> !pslverr)
    else $error("mapped access refused");
  a_one_access: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("access phase not exactly one cycle");
  a_wake_pulse: assert property (wake_event |-> osc_r ##1 !wake_event)
    else $error("wake event outside rtc or too long");
  a_irq_masked: assert property (wr_irq && !pwdata[`TMR_BIT_IRQ_EN] |-> ##2 !timer_irq)
    else $error("irq high with enable cleared");
  a_irq_sticky: assert property (timer_irq && !wr_irq && !$past(wr_irq) |=> timer_irq)
    else $error("irq dropped without software clear");
endmodule : tmr_asserts

bind tmr_timer tmr_asserts #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ext_clock_gate_pin(ext_clock_gate_pin),
  .lowpower_osc_clk(lowpower_osc_clk), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
  .timer_irq(timer_irq), .wake_event(wake_event));

// File: testbench/tmr_pin_model.sv
// partner model: external clock/gate pin and low-power oscillator
`timescale 1ns/1ns

module tmr_pin_model (
  input wire logic pclk,
  output logic pin,
  output logic osc
);
  // lines stand low outside frames
  initial begin
    pin = 1'b0;
    osc = 1'b0;
  end

  // each level lasts 3 pclk, above the 2 the synchroniser needs
  task automatic edges(input int n, input bit use_osc);
    repeat (n) begin
      repeat (3) @(posedge pclk);
      if (use_osc) osc <= 1'b1;
      else pin <= 1'b1;
      repeat (3) @(posedge pclk);
      osc <= 1'b0;
      pin <= 1'b0;
    end
    repeat (6) @(posedge pclk);
  endtask : edges

  // gate high for a span; its falling edge ends accumulation
  task automatic gate(input int cyc);
    @(posedge pclk);
    pin <= 1'b1;
    repeat (cyc) @(posedge pclk);
    pin <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : gate
endmodule : tmr_pin_model

// File: testbench/testbench.sv
// self-checking bench for the 16-bit timer
`timescale 1ns/1ns
`include "tmr_map.svh"

module testbench;
  import tmr_pkg::*;
  localparam logic [11:0] A_CNT = 12'(`TMR_IDX_COUNT * 4);
  localparam logic [11:0] A_PRD = 12'(`TMR_IDX_PERIOD * 4);
  localparam logic [11:0] A_CTL = 12'(`TMR_IDX_CTRL * 4);
  localparam logic [11:0] A_IRQ = 12'(`TMR_IDX_IRQ * 4);
  localparam logic [11:0] A_OSC = 12'(`TMR_IDX_OSC * 4);
  localparam logic [15:0] ON = 16'h8000, SIDL = 16'h2000, GATE = 16'h0040, SYNC = 16'h0004, SRC = 16'h0002;
  logic pclk, presetn, psel, penable, pwrite, cpu_idle, cpu_sleep;
  logic pready, pslverr, pin, osc, timer_irq, wake_event, wake_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int mismatches, check_count;

  tmr_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clock_gate_pin(pin), .lowpower_osc_clk(osc), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
    .timer_irq(timer_irq), .wake_event(wake_event));
  tmr_pin_model u_pins (.pclk(pclk), .pin(pin), .osc(osc));

  // clock and wake-pulse catcher
  always #25 pclk = ~pclk;
  always @(posedge pclk) if (wake_event === 1'b1) wake_seen <= 1'b1;

  // ==========================================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer; waits for pready, bounded so a stall is counted as a mismatch
  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    if (n >= 20) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 16'h0000);
    chk(rd, exp);
  endtask : rdc

  task automatic cfg(input logic [15:0] c, input logic [15:0] p);
    apb(1'b1, A_CTL, 16'h0000);
    apb(1'b1, A_PRD, p);
    apb(1'b1, A_CNT, 16'h0000);
    apb(1'b1, A_IRQ, 16'h0000);
    apb(1'b1, A_CTL, c);
  endtask : cfg

  // ==========================================================================
  // scenarios
  task automatic t_regs;
    rdc(A_PRD, 32'h0000FFFF);
    rdc(A_CTL, 32'h0);
    rdc(A_IRQ, 32'h0);
    apb(1'b1, A_CTL, 16'hFFFF);
    rdc(A_CTL, 32'h0000A076);
    apb(1'b1, A_CTL, 16'h0000);
    apb(1'b0, 12'h7FC, 16'h0000);
    chk({rd[31:1], pslverr}, 32'h1);
  endtask : t_regs

  task automatic t_sync;
    cfg(ON | SYNC | SRC, 16'd3);
    u_pins.edges(5, 1'b0);
    rdc(A_CNT, 32'd1);
    rdc(A_IRQ, 32'd1);
    apb(1'b1, A_IRQ, 16'h0000);
    rdc(A_IRQ, 32'd0);
    apb(1'b1, A_CTL, ON | SYNC | SRC);
    rdc(A_CNT, 32'd1);
  endtask : t_sync

  // every prescale code: twice the ratio in edges gives a count of two; the last ratio is 256, not 512
  task automatic t_prescale;
    for (int k = 0; k < 4; k++) begin
      cfg(ON | SYNC | SRC | 16'(k << 4), 16'hFFFF);
      u_pins.edges((k == 3) ? 512 : (2 << (3 * k)), 1'b0);
      rdc(A_CNT, 32'd2);
    end
  endtask : t_prescale

  task automatic t_psclear;
    cfg(ON | SYNC | SRC | 16'h0010, 16'hFFFF);
    u_pins.edges(6, 1'b0);
    apb(1'b1, A_CNT, 16'h0000);
    u_pins.edges(7, 1'b0);
    rdc(A_CNT, 32'd0);
    u_pins.edges(1, 1'b0);
    rdc(A_CNT, 32'd1);
  endtask : t_psclear

  task automatic t_idle_sleep;
    cpu_idle <= 1'b1;
    cfg(ON | SIDL, 16'hFFFF);
    repeat (20) @(posedge pclk);
    rdc(A_CNT, 32'd0);
    cfg(ON, 16'hFFFF);
    // counting starts the edge after the control write; the read setup samples one tick later
    rdc(A_CNT, 32'd1);
    cfg(ON | SIDL | SRC, 16'hFFFF);
    u_pins.edges(3, 1'b0);
    rdc(A_CNT, 32'd0);
    apb(1'b1, A_CTL, ON | SRC);
    u_pins.edges(2, 1'b0);
    rdc(A_CNT, 32'd2);
    cpu_idle <= 1'b0;
    cpu_sleep <= 1'b1;
    u_pins.edges(2, 1'b0);
    rdc(A_CNT, 32'd4);
    cfg(ON | SYNC | SRC, 16'hFFFF);
    u_pins.edges(3, 1'b0);
    rdc(A_CNT, 32'd0);
    cpu_sleep <= 1'b0;
  endtask : t_idle_sleep

  task automatic t_gate;
    cfg(ON | GATE, 16'hFFFF);
    u_pins.gate(10);
    // the synchronised gate stands high for exactly the ten cycles the pin did
    rdc(A_CNT, 32'd10);
    rdc(A_IRQ, 32'd1);
  endtask : t_gate

  // rtc: pin ignored, oscillator counted, wake pulse and gated irq
  task automatic t_rtc;
    apb(1'b1, A_OSC, 16'h0002);
    cfg(ON | SRC, 16'd2);
    apb(1'b1, A_IRQ, 16'h0002);
    u_pins.edges(2, 1'b0);
    rdc(A_CNT, 32'd0);
    // the rtc must keep counting through sleep
    cpu_sleep <= 1'b1;
    u_pins.edges(4, 1'b1);
    cpu_sleep <= 1'b0;
    rdc(A_CNT, 32'd1);
    chk({31'h0, wake_seen}, 32'h1);
    chk({31'h0, timer_irq}, 32'h1);
    apb(1'b1, A_IRQ, 16'h0001);
    repeat (3) @(posedge pclk);
    chk({31'h0, timer_irq}, 32'h0);
    apb(1'b1, A_OSC, 16'h0000);
  endtask : t_rtc

  task automatic print_verdict;
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, cpu_idle, cpu_sleep, wake_seen} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    mismatches = 0;
    check_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_sync;
    t_prescale;
    t_psclear;
    t_idle_sleep;
    t_gate;
    t_rtc;
    print_verdict;
  end
  initial begin
    repeat (30000) @(posedge pclk);
    mismatches++;
    print_verdict;
  end
endmodule : testbench
